// [shared/rsv_pkg.sv]
// Package: constants, register map and types of the reset supervisor and irq pin block
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package rsv_pkg;

  //----------------------------------------------------------------------
  // Timing
  //----------------------------------------------------------------------
  localparam int unsigned CLK_KHZ     = 20_000;
  localparam int unsigned TREC_MS     = 250;
  localparam int unsigned TRST_MS     = 250;
  localparam int unsigned PBDB_MS     = 250;
  localparam int unsigned TOSF_MS     = 100;
  localparam int unsigned TREC_CYC    = TREC_MS * CLK_KHZ;
  localparam int unsigned TRST_CYC    = TRST_MS * CLK_KHZ;
  localparam int unsigned PBDB_CYC    = PBDB_MS * CLK_KHZ;
  localparam int unsigned TOSF_CYC    = TOSF_MS * CLK_KHZ;
  localparam int unsigned CNT_W       = 23;

  //----------------------------------------------------------------------
  // Register map (index, byte address is four times it)
  //----------------------------------------------------------------------
  localparam logic [7:0]  CTRL_IDX    = 8'h0e;
  localparam logic [7:0]  STAT_IDX    = 8'h0f;
  localparam logic [7:0]  MASK_IDX    = 8'h10;
  localparam logic [7:0]  STATE_IDX   = 8'h11;
  localparam logic [7:0]  CTRL_RST    = 8'h3c;
  localparam logic [7:0]  CTRL_WMASK  = 8'hbf;
  localparam logic [4:0]  MASK_RST    = 5'h00;

  // Status and mask bit positions
  localparam int unsigned EV_ALARM1   = 0;
  localparam int unsigned EV_ALARM2   = 1;
  localparam int unsigned EV_OSCSTOP  = 2;
  localparam int unsigned EV_PRESS    = 3;
  localparam int unsigned EV_PWRFAIL  = 4;
  localparam int unsigned EV_W        = 5;

  // Divider bit per rate code: 1 Hz, 1.024 kHz, 4.096 kHz, 8.192 kHz
  localparam int unsigned DIV_W       = 15;
  localparam int unsigned RATE0_BIT   = 14;
  localparam int unsigned RATE1_BIT   = 4;
  localparam int unsigned RATE2_BIT   = 2;
  localparam int unsigned RATE3_BIT   = 1;

  //----------------------------------------------------------------------
  // Types
  //----------------------------------------------------------------------
  typedef struct packed {
    logic oscillator_disable_n;
    logic rsvd;
    logic ref_clock_en;
    logic rate_select_high;
    logic rate_select_low;
    logic irq_or_square_select;
    logic alarm2_en;
    logic alarm1_en;
  } rsv_ctrl_type;

  typedef enum logic [1:0] {
    RSV_PFAIL = 2'b00,
    RSV_RECOV = 2'b01,
    RSV_RUN   = 2'b10,
    RSV_PUSH  = 2'b11
  } rsv_state_type;

  // Byte address of a register index
  function automatic logic [9:0] idx2addr(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction

endpackage

// [rtl/rsv_debounce.sv]
// Debouncer for the pushbutton sense of the reset pin
`timescale 1ns/1ps
module rsv_debounce
#(
  parameter int unsigned DB_CYC = rsv_pkg::PBDB_CYC
)
(
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic sense,
  output logic      press
);
  import rsv_pkg::*;

  logic             stable_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             settle;

  //----------------------------------------------------------------------
  // Stability counter
  //----------------------------------------------------------------------
  // Any bounce back to the held level restarts the wait
  assign settle  = (sense != stable_r) && (cnt_r >= CNT_W'(DB_CYC - 1));
  assign cnt_nxt = (sense == stable_r || settle) ? '0 : cnt_r + CNT_W'(1);

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stable_r <= 1'b1;
      cnt_r    <= '0;
      press    <= 1'b0;
    end
    else
    begin
      cnt_r    <= cnt_nxt;
      stable_r <= settle ? sense : stable_r;
      press    <= settle && !sense;  // Only a settled fall counts
    end
  end

endmodule // rsv_debounce

// [rtl/rsv_top.sv]
// Reset supervisor, multifunction irq/square pin and reference clock output
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module rsv_top
#(
  parameter int unsigned TREC_P = rsv_pkg::TREC_CYC,
  parameter int unsigned TRST_P = rsv_pkg::TRST_CYC,
  parameter int unsigned PBDB_P = rsv_pkg::PBDB_CYC,
  parameter int unsigned TOSF_P = rsv_pkg::TOSF_CYC
)
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // APB slave
  input  wire logic [9:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  // Analogue and neighbouring blocks
  input  wire logic        vcc_above_pf,
  input  wire logic        osc_in,
  input  wire logic        alarm1_match,
  input  wire logic        alarm2_match,
  // Open-drain pins
  input  wire logic        rst_pin_in,
  output logic             rst_pin_out,
  output logic             rst_pin_oe,
  output logic             irq_or_square_pin_out,
  output logic             irq_or_square_pin_oe,
  output logic             ref_clock_out_out,
  output logic             ref_clock_out_oe
);
  import rsv_pkg::*;

  rsv_ctrl_type       ctrl_r;
  logic [EV_W-1:0]    stat_r;
  logic [EV_W-1:0]    stat_nxt;
  logic [EV_W-1:0]    stat_clr;
  logic [EV_W-1:0]    mask_r;
  logic [EV_W-1:0]    events;
  rsv_state_type      state_r;
  rsv_state_type      state_nxt;
  logic [CNT_W-1:0]   cnt_r;
  logic [CNT_W-1:0]   cnt_nxt;
  logic [CNT_W-1:0]   osc_idle_r;
  logic [DIV_W-1:0]   div_r;
  logic [DIV_W-1:0]   div_nxt;
  logic               osc_d_r;
  logic               osc_rise;
  logic               osc_stop;
  logic               osc_stop_d_r;
  logic               vcc_d_r;
  logic               sel_d_r;
  logic               sel_chg;
  logic               sq_level;
  logic               alarm_act;
  logic               irq_drive_r;
  logic               irq_drive_nxt;
  logic               rst_drive_r;
  logic               press;
  logic               cnt_done;
  logic               irq_r;
  logic [31:0]        rdata_r;
  logic [31:0]        rmux;
  logic [31:0]        ctrl_word;
  logic [31:0]        stat_word;
  logic [31:0]        mask_word;
  logic [31:0]        state_word;
  logic               setup;
  logic               access;
  logic               hit_ctrl;
  logic               hit_stat;
  logic               hit_mask;
  logic               hit_state;
  logic               mapped;
  logic               wr_ctrl;
  logic               wr_mask;
  logic               rd_stat;

  //----------------------------------------------------------------------
  // Helper functions
  //----------------------------------------------------------------------
  // Square wave level for a rate code
  function automatic logic rate_tap(input logic [1:0] rs, input logic [DIV_W-1:0] d);
    logic t;
    t = 1'b0;
    unique case (rs)
      2'b00: t = d[RATE0_BIT];
      2'b01: t = d[RATE1_BIT];
      2'b10: t = d[RATE2_BIT];
      2'b11: t = d[RATE3_BIT];
    endcase
    return t;
  endfunction

  // Counter has reached a cycle figure
  function automatic logic reached(input logic [CNT_W-1:0] c, input int unsigned n);
    return c >= CNT_W'(n - 1);
  endfunction

  //----------------------------------------------------------------------
  // APB decode
  //----------------------------------------------------------------------
  // Zero wait state; read data is caught in the setup cycle
  // Only the low byte lane carries fields, so only pstrb[0] qualifies a write
  assign setup     = psel && !penable;
  assign access    = psel && penable;
  assign hit_ctrl  = paddr == idx2addr(CTRL_IDX);
  assign hit_stat  = paddr == idx2addr(STAT_IDX);
  assign hit_mask  = paddr == idx2addr(MASK_IDX);
  assign hit_state = paddr == idx2addr(STATE_IDX);
  assign mapped    = hit_ctrl || hit_stat || hit_mask || hit_state;
  assign pready    = access;
  assign pslverr   = access && !mapped;
  assign prdata    = rdata_r;
  assign wr_ctrl   = access && pwrite && hit_ctrl && pstrb[0];
  assign wr_mask   = access && pwrite && hit_mask && pstrb[0];
  assign rd_stat   = access && !pwrite && hit_stat;

  // Register words; bits above each field read as zero
  assign ctrl_word  = 32'(ctrl_r);
  assign stat_word  = 32'(stat_r);
  assign mask_word  = 32'(mask_r);
  assign state_word = 32'({!osc_stop, rst_drive_r, state_r});

  // Read mux; the state word shows the pin drive and oscillator
  // Unmapped places read zero and are refused in the access cycle
  assign rmux = hit_ctrl  ? ctrl_word  :
                hit_stat  ? stat_word  :
                hit_mask  ? mask_word  :
                hit_state ? state_word :
                            32'h0000_0000;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      rdata_r <= 32'h0000_0000;
    else if (setup)
      rdata_r <= rmux;
  end

  //----------------------------------------------------------------------
  // Control and mask registers
  //----------------------------------------------------------------------
  // Bus access never looks at the reset pin, so software keeps working
  // Reserved bit 6 is masked on write so it always reads as zero
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_r <= rsv_ctrl_type'(CTRL_RST);  // Irq mode, alarms off
      mask_r <= MASK_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= rsv_ctrl_type'(pwdata[7:0] & CTRL_WMASK);
      if (wr_mask)
        mask_r <= pwdata[EV_W-1:0];
    end
  end

  //----------------------------------------------------------------------
  // Oscillator watch
  //----------------------------------------------------------------------
  // Oscillator input is treated as synchronous to core_clk
  // An asynchronous source needs two flops ahead of osc_in; every
  // oscillator count below would then lag by those two cycles
  assign osc_rise = osc_in && !osc_d_r;
  assign osc_stop = reached(osc_idle_r, TOSF_P);

  // Idle counter saturates so the flag holds while stopped
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      osc_d_r      <= 1'b0;
      osc_idle_r   <= '0;
      osc_stop_d_r <= 1'b0;
    end
    else
    begin
      osc_d_r      <= osc_in;
      osc_stop_d_r <= osc_stop;
      if (osc_rise)
        osc_idle_r <= '0;
      else if (!osc_stop)
        osc_idle_r <= osc_idle_r + CNT_W'(1);
    end
  end

  //----------------------------------------------------------------------
  // Reference clock output
  //----------------------------------------------------------------------
  // No supply term: runs on primary or backup alike
  // Pin follows the delayed oscillator level, one cycle behind osc_in
  assign ref_clock_out_out = 1'b0;
  assign ref_clock_out_oe  = ctrl_r.ref_clock_en && !osc_d_r;

  //----------------------------------------------------------------------
  // Pushbutton sense
  //----------------------------------------------------------------------
  // Own drive reads as high so our pulse is never taken for a press
  // A button still held when our drive ends must settle again to count
  rsv_debounce #(
    .DB_CYC   (PBDB_P)
  ) u_debounce (
    .core_clk (core_clk),
    .resetn   (resetn),
    .sense    (rst_pin_in || rst_drive_r),
    .press    (press)
  );

  //----------------------------------------------------------------------
  // Reset sequencer
  //----------------------------------------------------------------------
  // One counter serves both recovery and active time; the state picks the end
  assign cnt_done = (state_r == RSV_RECOV) ? reached(cnt_r, TREC_P) :
                                             reached(cnt_r, TRST_P);

  // Supply loss overrides every state
  always_comb
  begin
    state_nxt = state_r;
    if (!vcc_above_pf)
      state_nxt = RSV_PFAIL;
    else
    begin
      unique case (state_r)
        RSV_PFAIL:
          state_nxt = ctrl_r.oscillator_disable_n ? RSV_RUN : RSV_RECOV;
        RSV_RECOV:
          if (ctrl_r.oscillator_disable_n)
            state_nxt = RSV_RUN;
          else if (cnt_done && !osc_stop)
            state_nxt = RSV_RUN;
        RSV_RUN:
          if (press)
            state_nxt = RSV_PUSH;
        RSV_PUSH:
          if (cnt_done)
            state_nxt = RSV_RUN;  // Presses ignored until here
      endcase
    end
  end

  // Recovery only counts while the oscillator runs
  assign cnt_nxt = (state_nxt != state_r) ? '0 :
                   (state_r == RSV_RECOV && osc_stop) ? cnt_r :
                   cnt_r + CNT_W'(1);

  // Pin drive is taken from the next state, so it moves with the state
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r     <= RSV_PFAIL;
      cnt_r       <= '0;
      rst_drive_r <= 1'b1;
    end
    else
    begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      rst_drive_r <= state_nxt != RSV_RUN;
    end
  end

  assign rst_pin_out = 1'b0;
  assign rst_pin_oe  = rst_drive_r;

  //----------------------------------------------------------------------
  // Multifunction pin
  //----------------------------------------------------------------------
  // Both functions share one drive flop, so the pin never sees decode glitches
  assign sel_chg   = ctrl_r.irq_or_square_select != sel_d_r;
  assign sq_level  = rate_tap({ctrl_r.rate_select_high, ctrl_r.rate_select_low}, div_r);
  assign alarm_act = (stat_r[EV_ALARM1] && ctrl_r.alarm1_en) ||
                     (stat_r[EV_ALARM2] && ctrl_r.alarm2_en);

  // Divider restarts on a mode change so the first half wave is whole
  assign div_nxt = sel_chg  ? '0 :
                   osc_rise ? div_r + DIV_W'(1) : div_r;

  // Released for the change cycle, then the new function takes over
  assign irq_drive_nxt = sel_chg ? 1'b0 :
                         ctrl_r.irq_or_square_select ? alarm_act :
                         !sq_level;

  // Select history, divider and pin drive
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sel_d_r     <= 1'b1;
      div_r       <= '0;
      irq_drive_r <= 1'b0;
    end
    else
    begin
      sel_d_r     <= ctrl_r.irq_or_square_select;
      div_r       <= div_nxt;
      irq_drive_r <= irq_drive_nxt;
    end
  end

  assign irq_or_square_pin_out = 1'b0;
  assign irq_or_square_pin_oe  = irq_drive_r;

  //----------------------------------------------------------------------
  // Event status and interrupt
  //----------------------------------------------------------------------
  // Event pulses; power fail is the falling edge of the supply flag
  assign events[EV_ALARM1]  = alarm1_match;
  assign events[EV_ALARM2]  = alarm2_match;
  assign events[EV_OSCSTOP] = osc_stop && !osc_stop_d_r;
  assign events[EV_PRESS]   = press && state_r == RSV_RUN;
  assign events[EV_PWRFAIL] = vcc_d_r && !vcc_above_pf;

  // Read clears only the bits that went out in the read word; an event
  // landing between the setup and access edges stays pending, and an
  // event in the clear cycle itself wins over the clear
  assign stat_clr = rd_stat ? rdata_r[EV_W-1:0] : '0;
  assign stat_nxt = (stat_r & ~stat_clr) | events;

  // irq is taken from the next status, so it rises with its status bit
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stat_r  <= '0;
      vcc_d_r <= 1'b0;
      irq_r   <= 1'b0;
    end
    else
    begin
      stat_r  <= stat_nxt;
      vcc_d_r <= vcc_above_pf;
      irq_r   <= |(stat_nxt & mask_r);
    end
  end

  assign irq = irq_r;

endmodule // rsv_top

// [tb/rsv_assertions.sv]
// Port-level concurrent checks of the reset supervisor block
`timescale 1ns/1ps
module rsv_assertions
  import rsv_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic [9:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        vcc_above_pf,
  input wire logic        osc_in,
  input wire logic        alarm1_match,
  input wire logic        rst_pin_out,
  input wire logic        rst_pin_oe,
  input wire logic        irq_or_square_pin_out,
  input wire logic        irq_or_square_pin_oe,
  input wire logic        ref_clock_out_out,
  input wire logic        ref_clock_out_oe
);
  // ----------------------------------------
  // Shadow of the control byte
  // ----------------------------------------
  rsv_ctrl_type ctl_r;
  logic [1:0]   age_r;

  // Write decode mirrors the slave; unmapped places never write
  wire ctl_wr = psel && penable && pwrite && pstrb[0] && (paddr == {CTRL_IDX, 2'h0});
  wire mapped = paddr[9:2] inside {CTRL_IDX, STAT_IDX, MASK_IDX, STATE_IDX};

  // Updated on the same edge as the device's own copy
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
      ctl_r <= rsv_ctrl_type'(CTRL_RST);
    else if (ctl_wr)
      ctl_r <= rsv_ctrl_type'(pwdata[7:0]);

  // Oscillator history is unknown for the first edges after reset
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
      age_r <= 2'h0;
    else if (age_r != 2'h3)
      age_r <= age_r + 2'h1;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  a_pf_low: assert property (!vcc_above_pf |=> rst_pin_oe)
    else $error("reset pin released during power fail");
  a_od_zero: assert property (!rst_pin_out && !irq_or_square_pin_out && !ref_clock_out_out)
    else $error("open drain pin drives high");
  a_rec_hold: assert property ($rose(vcc_above_pf) && !ctl_r.oscillator_disable_n
    |=> rst_pin_oe [*8])
    else $error("recovery interval cut short");
  a_osc_skip: assert property ($rose(vcc_above_pf) && ctl_r.oscillator_disable_n
    |-> ##[1:3] !rst_pin_oe)
    else $error("recovery not skipped");
  a_apb_ready: assert property (psel && penable |-> pready)
    else $error("no zero wait answer");
  a_unmapped_err: assert property (psel && penable && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  a_alarm_pin: assert property ($rose(alarm1_match) && ctl_r.irq_or_square_select
    && ctl_r.alarm1_en |-> ##[1:2] irq_or_square_pin_oe)
    else $error("enabled alarm did not pull pin");
  a_alarm_off: assert property ((ctl_r.irq_or_square_select && !ctl_r.alarm1_en
    && !ctl_r.alarm2_en) [*2] |-> !irq_or_square_pin_oe)
    else $error("pin pulled with alarms disabled");
  a_sel_release: assert property ($changed(ctl_r.irq_or_square_select)
    |-> ##[0:1] !irq_or_square_pin_oe)
    else $error("pin not released on function change");
  a_push_hold: assert property ($rose(rst_pin_oe) && vcc_above_pf && $past(vcc_above_pf)
    |=> rst_pin_oe [*8])
    else $error("pushbutton reset too short");
  a_ref_follow: assert property (age_r == 2'h3
    |-> ref_clock_out_oe == (ctl_r.ref_clock_en && !$past(osc_in)))
    else $error("reference output not following oscillator");
endmodule // rsv_assertions

bind rsv_top rsv_assertions chk_u (.core_clk, .resetn, .paddr, .psel, .penable, .pwrite,
  .pwdata, .pstrb, .pready, .pslverr, .vcc_above_pf, .osc_in, .alarm1_match, .rst_pin_out,
  .rst_pin_oe, .irq_or_square_pin_out, .irq_or_square_pin_oe, .ref_clock_out_out,
  .ref_clock_out_oe);

// [tb/rsv_host_model.sv]
// Host reset input and pushbutton sharing the open-drain reset line
`timescale 1ns/1ps
module rsv_host_model
(
  input  wire logic core_clk,
  input  wire logic rst_pin_out,
  input  wire logic rst_pin_oe,
  input  wire logic button,
  output logic      rst_pin_in,
  output logic      host_in_reset
);
  logic [1:0] bounce_r = 2'h0;

  // Contact bounces once at closing, so a naive edge detector is caught
  always_ff @(posedge core_clk)
    bounce_r <= !button ? 2'h0 : (bounce_r == 2'h3) ? 2'h3 : bounce_r + 2'h1;

  // Pull-up holds the line high unless device or contact pulls low
  assign rst_pin_in = !((rst_pin_oe && !rst_pin_out) || (button && bounce_r != 2'h1));
  assign host_in_reset = !rst_pin_in;
endmodule // rsv_host_model

// [tb/testbench.sv]
// Self-checking testbench of the reset supervisor block
`timescale 1ns/1ps
module testbench;
  import rsv_pkg::*;
  localparam int unsigned TRP = 20;
  localparam int unsigned TSP = 20;
  localparam int unsigned DBP = 10;
  localparam int unsigned OSP = 50;
  localparam logic [9:0] A_CTL = {CTRL_IDX, 2'h0};
  localparam logic [9:0] A_STA = {STAT_IDX, 2'h0};
  localparam logic [9:0] A_MSK = {MASK_IDX, 2'h0};

  logic        core_clk = 1'h0;
  logic        resetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [9:0]  paddr = 10'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'h0;
  logic        vcc_above_pf = 1'h1;
  logic        osc_run = 1'h1;
  logic [2:0]  osc_cnt = 3'h0;
  logic        alarm1_match = 1'h0;
  logic        alarm2_match = 1'h0;
  logic        button = 1'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, irq, err, rst_pin_in, rst_pin_out, rst_pin_oe, host_rst;
  logic        irq_or_square_pin_out, irq_or_square_pin_oe;
  logic        ref_clock_out_out, ref_clock_out_oe;
  wire         osc_in = osc_cnt[2];
  int          miscompares = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          n;

  // Clock and an oscillator of eight core cycles that can be stopped
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (osc_run)
      osc_cnt <= osc_cnt + 3'h1;

  rsv_top #(.TREC_P(TRP), .TRST_P(TSP), .PBDB_P(DBP), .TOSF_P(OSP)) dut_u (.core_clk,
    .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .irq, .vcc_above_pf, .osc_in, .alarm1_match, .alarm2_match, .rst_pin_in, .rst_pin_out,
    .rst_pin_oe, .irq_or_square_pin_out, .irq_or_square_pin_oe, .ref_clock_out_out,
    .ref_clock_out_oe);
  rsv_host_model host_u (.core_clk, .rst_pin_out, .rst_pin_oe, .button, .rst_pin_in,
    .host_in_reset(host_rst));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task print_verdict;
    if (miscompares == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One transfer; held until pready is seen at a rising edge
  task apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge core_clk);
    penable <= 1'h1;
    @(posedge core_clk);
    while (pready !== 1'h1)
      @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task rdchk(input logic [9:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0000_0000);
    chk(rd, e);
  endtask

  task wait_rst(input logic v);
    n = 0;
    while (rst_pin_oe !== v && n < 500)
    begin
      @(posedge core_clk);
      n++;
    end
  endtask

  task wait_sq;
    logic v;
    v = irq_or_square_pin_oe;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (irq_or_square_pin_oe === v && n < 500);
  endtask

  task pulse(input logic two);
    alarm1_match <= !two;
    alarm2_match <= two;
    @(posedge core_clk);
    alarm1_match <= 1'h0;
    alarm2_match <= 1'h0;
    repeat (3) @(posedge core_clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    wait_rst(1'h0);
    chk(n >= TRP - 1 && n <= TRP + 12, 1'h1);
    rdchk(A_CTL, 32'h0000_003c);
    chk(irq_or_square_pin_oe, 1'h0);
    rdchk(10'h3fc, 32'h0000_0000);
    chk(err, 1'h1);
    rdchk(A_MSK, 32'h0000_0000);
  endtask

  task t_power;
    apb(1'h0, A_STA, 32'h0000_0000);
    vcc_above_pf <= 1'h0;
    repeat (3) @(posedge core_clk);
    chk(host_rst, 1'h1);
    rdchk(A_CTL, 32'h0000_003c);
    vcc_above_pf <= 1'h1;
    wait_rst(1'h0);
    chk(n >= TRP - 1 && n <= TRP + 12, 1'h1);
    rdchk(A_STA, 32'h0000_0010);
    apb(1'h1, A_CTL, 32'h0000_00bc);
    vcc_above_pf <= 1'h0;
    repeat (3) @(posedge core_clk);
    vcc_above_pf <= 1'h1;
    wait_rst(1'h0);
    chk(n <= 3, 1'h1);
    apb(1'h1, A_CTL, 32'h0000_003c);
    apb(1'h0, A_STA, 32'h0000_0000);
  endtask

  // Button held through the active time: a second press must not count
  task t_press;
    apb(1'h1, A_MSK, 32'h0000_0008);
    button <= 1'h1;
    wait_rst(1'h1);
    chk(n >= DBP && n <= DBP + 8, 1'h1);
    wait_rst(1'h0);
    button <= 1'h0;
    chk(n >= TSP - 1 && n <= TSP + 2, 1'h1);
    chk(irq, 1'h1);
    rdchk(A_STA, 32'h0000_0008);
    repeat (2) @(posedge core_clk);
    chk(irq, 1'h0);
    apb(1'h1, A_MSK, 32'h0000_0000);
  endtask

  task t_square;
    int tap [4];
    tap = '{RATE0_BIT, RATE1_BIT, RATE2_BIT, RATE3_BIT};
    for (int r = 3; r > 0; r--)
    begin
      apb(1'h1, A_CTL, 32'h0000_0020 | (r << 3));
      // First changes may be a restart or a cut half wave; time a whole one
      wait_sq;
      wait_sq;
      wait_sq;
      chk(n, 8 << tap[r]);
    end
    apb(1'h1, A_CTL, 32'h0000_003c);
    apb(1'h1, A_CTL, 32'h0000_0020);
    repeat (3) @(posedge core_clk);
    wait_sq;
    chk(n, 500);
  endtask

  // Alarm 2 left disabled and masked: neither pin nor irq may move
  task t_alarm;
    apb(1'h1, A_CTL, 32'h0000_003d);
    apb(1'h1, A_MSK, 32'h0000_0001);
    apb(1'h0, A_STA, 32'h0000_0000);
    pulse(1'h0);
    chk({irq, irq_or_square_pin_oe}, 2'h3);
    rdchk(A_STA, 32'h0000_0001);
    repeat (2) @(posedge core_clk);
    chk({irq, irq_or_square_pin_oe}, 2'h0);
    pulse(1'h1);
    chk({irq, irq_or_square_pin_oe}, 2'h0);
    rdchk(A_STA, 32'h0000_0002);
    apb(1'h1, A_CTL, 32'h0000_003c);
  endtask

  task t_osc;
    apb(1'h1, A_MSK, 32'h0000_0004);
    n = 0;
    repeat (8)
    begin
      @(posedge core_clk);
      n += ref_clock_out_oe;
    end
    chk(n, 4);
    osc_run <= 1'h0;
    repeat (OSP - 15) @(posedge core_clk);
    rdchk(A_STA, 32'h0000_0000);
    repeat (20) @(posedge core_clk);
    chk(irq, 1'h1);
    rdchk(A_STA, 32'h0000_0004);
    osc_run <= 1'h1;
  endtask

  // Hang guard well above the fewer than two thousand cycles the run needs
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      print_verdict;
    end
  end

  initial
  begin
    repeat (3) @(posedge core_clk);
    resetn <= 1'h1;
    t_reset;
    t_power;
    t_press;
    t_square;
    t_alarm;
    t_osc;
    print_verdict;
  end
endmodule // testbench
